// ===== rtl/power_mgmt_control_status.sv
// power management control/status word with power data report on ahb-lite
`timescale 1ns/1ps
`include "pm_status_regs.svh"

// Functional notes
// - wake event sets sticky wake status bit 15 regardless of wake enable
// - host writing one to wake status clears it
// - that clear also releases wake pin and clears driver-side status copy
// - with wake enabled, wake pin follows wake status bit
// - in cardbus mode, clearing also clears the general wake flag
// - wake pin asserted only when enable bit 8 set; enable resets zero
// - scale bits 14:13 read 10b for index 0..8, 00b for 9..15
// - index bits 12:9 select reported entry; reset zero
// - dynamic monitoring bit 4 always reads zero
// - reserved bits 7:5 and 3:2 read zero
// - power state bits 1:0 read current state, write sets it, reset 00b
// - state codes 00 D0, 01 D1, 10 D2, 11 D3
// - 8-bit read-only power data byte chosen by written index
// - data in 0.01 W steps, range 0 to 2.55 W, per scale
// - data 60 for 0,4; 42 for 1-3,5-7; 00 for 8..15
module power_mgmt_control_status
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// wake event source and pin
	input wire logic wake_event,
	output logic pme_n_out,
	output logic pme_n_oe,
	// power state and flags to the rest of the function
	output pm_status_pkg::power_state_t power_state,
	output logic driver_wake_status,
	output logic general_wake_flag
);

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	pm_status_pkg::ahb_req_t req_reg;
	logic wake_status_reg;
	logic wake_enable_reg;
	logic [3:0] data_index_reg;
	pm_status_pkg::power_state_t power_state_reg;
	logic cardbus_mode_reg;
	logic drv_wake_reg;
	logic gen_wake_reg;
	logic pme_assert_reg;
	logic [31:0] rdata_reg;
	logic wake_sync1_reg;
	logic wake_sync2_reg;
	logic wake_seen_reg;
	logic wake_pulse;
	logic wr_csr;
	logic wr_aux;
	logic clear_wake;
	logic [1:0] scale_value;
	logic [7:0] data_value;
	logic [15:0] csr_value;
	logic [31:0] rdata_next;

	//------------------------------------------------------------
	// bus address phase capture
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			req_reg <= '0;
		else if (hready)
		begin
			req_reg.sel <= hsel && htrans == `PM_HTRANS_NONSEQ;
			req_reg.trans <= htrans;
			req_reg.write <= hwrite;
			req_reg.size <= hsize;
			req_reg.addr <= haddr;
		end
		else
			req_reg.sel <= 1'b0;
	end

	assign wr_csr = req_reg.sel && req_reg.write
		&& req_reg.addr == `PM_CSR_OFFSET;
	assign wr_aux = req_reg.sel && req_reg.write
		&& req_reg.addr == `PM_AUX_OFFSET;
	assign clear_wake = wr_csr && hwdata[`PM_WAKE_STATUS_BIT];

	//------------------------------------------------------------
	// wake event input sync and edge
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wake_sync1_reg <= 1'b0;
			wake_sync2_reg <= 1'b0;
			wake_seen_reg <= 1'b0;
		end
		else
		begin
			wake_sync1_reg <= wake_event;
			wake_sync2_reg <= wake_sync1_reg;
			wake_seen_reg <= wake_sync2_reg;
		end
	end

	assign wake_pulse = wake_sync2_reg && !wake_seen_reg;

	//------------------------------------------------------------
	// sticky wake status, set beats clear
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			wake_status_reg <= 1'b0;
		else if (wake_pulse)
			wake_status_reg <= 1'b1;
		else if (clear_wake)
			wake_status_reg <= 1'b0;
	end

	// driver-side copy and general wake flag
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			drv_wake_reg <= 1'b0;
			gen_wake_reg <= 1'b0;
		end
		else
		begin
			if (wake_pulse)
				drv_wake_reg <= 1'b1;
			else if (clear_wake)
				drv_wake_reg <= 1'b0;
			if (wake_pulse)
				gen_wake_reg <= 1'b1;
			else if (clear_wake && cardbus_mode_reg)
				gen_wake_reg <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// writable control fields
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wake_enable_reg <= 1'b0;
			data_index_reg <= `PM_INDEX_RESET;
			power_state_reg <= pm_status_pkg::PWR_D0;
		end
		else if (wr_csr)
		begin
			wake_enable_reg <= hwdata[`PM_WAKE_ENABLE_BIT];
			data_index_reg <= hwdata[`PM_INDEX_HI:`PM_INDEX_LO];
			power_state_reg <= pm_status_pkg::power_state_t'(
				hwdata[`PM_STATE_HI:`PM_STATE_LO]);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cardbus_mode_reg <= 1'b0;
		else if (wr_aux)
			cardbus_mode_reg <= hwdata[`PM_AUX_CARDBUS_BIT];
	end

	//------------------------------------------------------------
	// wake pin: low-active, open drain
	//------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			pme_assert_reg <= 1'b0;
		else
			pme_assert_reg <= wake_enable_reg && wake_status_reg
				&& !clear_wake;
	end

	//------------------------------------------------------------
	// power data table and read mux
	//------------------------------------------------------------
	always_comb
	begin
		if (data_index_reg <= `PM_INDEX_LAST_SCALED)
			scale_value = `PM_SCALE_LOW_SET;
		else
			scale_value = `PM_SCALE_HIGH_SET;
		unique case (data_index_reg)
			4'h0, 4'h4: data_value = `PM_DATA_D0;
			4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7:
				data_value = `PM_DATA_DX;
			default: data_value = `PM_DATA_NONE;
		endcase
	end

	always_comb
	begin
		csr_value = 16'h0000;
		csr_value[`PM_WAKE_STATUS_BIT] = wake_status_reg;
		csr_value[`PM_SCALE_HI:`PM_SCALE_LO] = scale_value;
		csr_value[`PM_INDEX_HI:`PM_INDEX_LO] = data_index_reg;
		csr_value[`PM_WAKE_ENABLE_BIT] = wake_enable_reg;
		csr_value[`PM_STATE_HI:`PM_STATE_LO] = power_state_reg;
		rdata_next = 32'h0000_0000;
		if (hsel && htrans == `PM_HTRANS_NONSEQ && !hwrite)
		begin
			if (haddr == `PM_CSR_OFFSET)
				rdata_next = {16'h0000, csr_value};
			else if (haddr == `PM_DATA_OFFSET)
				rdata_next = {24'h00_0000, data_value};
			else if (haddr == `PM_AUX_OFFSET)
			begin
				rdata_next[`PM_AUX_DRV_WAKE_BIT] = drv_wake_reg;
				rdata_next[`PM_AUX_GEN_WAKE_BIT] = gen_wake_reg;
				rdata_next[`PM_AUX_CARDBUS_BIT] = cardbus_mode_reg;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_reg <= 32'h0000_0000;
		else if (hready)
			rdata_reg <= rdata_next;
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	assign hrdata = rdata_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pme_n_out = 1'b0;
	assign pme_n_oe = pme_assert_reg;
	assign power_state = power_state_reg;
	assign driver_wake_status = drv_wake_reg;
	assign general_wake_flag = gen_wake_reg;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	sequence s_clear_write;
		wr_csr && hwdata[`PM_WAKE_STATUS_BIT] && !wake_pulse;
	endsequence

	a_wake_sets: assert property (@(posedge clk) disable iff (rst)
		wake_pulse |=> wake_status_reg)
		else $error("wake status not set by event");
	a_wake_clears: assert property (@(posedge clk) disable iff (rst)
		s_clear_write |=> !wake_status_reg && !drv_wake_reg)
		else $error("wake status not cleared by write");
	a_pin_release: assert property (@(posedge clk) disable iff (rst)
		s_clear_write |=> !pme_n_oe)
		else $error("wake pin held after clear");
	a_pin_follows: assert property (@(posedge clk) disable iff (rst)
		wake_enable_reg && wake_status_reg && !clear_wake |=> pme_n_oe)
		else $error("wake pin not following status");
	a_gen_wake_clear: assert property (@(posedge clk) disable iff (rst)
		s_clear_write ##0 cardbus_mode_reg |=> !gen_wake_reg)
		else $error("general wake flag not cleared");
	a_pin_gated: assert property (@(posedge clk) disable iff (rst)
		pme_n_oe |-> $past(wake_enable_reg))
		else $error("wake pin without enable");
	a_scale_field: assert property (@(posedge clk) disable iff (rst)
		scale_value == (data_index_reg > 4'h8 ? 2'h0 : 2'h2))
		else $error("scale field wrong");
	a_data_table: assert property (@(posedge clk) disable iff (rst)
		data_index_reg == 4'h4 |-> data_value == 8'h3C)
		else $error("power data wrong");
	a_state_write: assert property (@(posedge clk) disable iff (rst)
		wr_csr |=> power_state_reg == $past(hwdata[1:0]))
		else $error("power state not written");
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		csr_value[7:2] == 6'h00)
		else $error("reserved bits not zero");

	//------------------------------------------------------------
	// checks: stored fields, data table and read path
	//------------------------------------------------------------
	sequence s_quiet_cycle;
		!wake_pulse && !clear_wake;
	endsequence

	sequence s_read_csr;
		hready && hsel && htrans == `PM_HTRANS_NONSEQ && !hwrite
			&& haddr == `PM_CSR_OFFSET;
	endsequence

	sequence s_read_data;
		hready && hsel && htrans == `PM_HTRANS_NONSEQ && !hwrite
			&& haddr == `PM_DATA_OFFSET;
	endsequence

	a_index_write: assert property (@(posedge clk) disable iff (rst)
		wr_csr |=> data_index_reg == $past(hwdata[12:9]))
		else $error("data index not written");
	a_enable_write: assert property (@(posedge clk) disable iff (rst)
		wr_csr |=> wake_enable_reg == $past(hwdata[8]))
		else $error("wake enable not written");
	a_fields_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_csr |=> $stable(data_index_reg) && $stable(power_state_reg))
		else $error("control field changed without write");
	a_status_hold: assert property (@(posedge clk) disable iff (rst)
		s_quiet_cycle |=> $stable(wake_status_reg))
		else $error("wake status changed without cause");
	a_drv_hold: assert property (@(posedge clk) disable iff (rst)
		s_quiet_cycle |=> $stable(drv_wake_reg))
		else $error("driver copy changed without cause");
	a_drv_sets: assert property (@(posedge clk) disable iff (rst)
		wake_pulse |=> drv_wake_reg)
		else $error("driver copy not set by event");
	a_gen_wake_keep: assert property (@(posedge clk) disable iff (rst)
		s_clear_write ##0 !cardbus_mode_reg |=> $stable(gen_wake_reg))
		else $error("general wake flag cleared outside cardbus");
	a_pin_status: assert property (@(posedge clk) disable iff (rst)
		pme_n_oe |-> $past(wake_status_reg))
		else $error("wake pin without status");
	a_read_csr: assert property (@(posedge clk) disable iff (rst)
		s_read_csr |=> hrdata == {16'h0000, $past(csr_value)})
		else $error("control word read wrong");
	a_read_data: assert property (@(posedge clk) disable iff (rst)
		s_read_data |=> hrdata == {24'h00_0000, $past(data_value)})
		else $error("power data read wrong");
	a_data_first: assert property (@(posedge clk) disable iff (rst)
		data_index_reg == 4'h0 |-> data_value == `PM_DATA_D0)
		else $error("power data for entry zero wrong");
	a_data_dx: assert property (@(posedge clk) disable iff (rst)
		data_index_reg inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}
		|-> data_value == `PM_DATA_DX)
		else $error("power data for low states wrong");
	a_data_none: assert property (@(posedge clk) disable iff (rst)
		data_index_reg >= `PM_INDEX_LAST_SCALED |-> data_value == `PM_DATA_NONE)
		else $error("power data for upper entries wrong");
	a_dynamic_zero: assert property (@(posedge clk) disable iff (rst)
		csr_value[`PM_DYNAMIC_BIT] == 1'b0)
		else $error("dynamic monitoring bit set");

endmodule // power_mgmt_control_status

// ===== rtl/pm_status_regs.svh
// offsets, field positions, reset values and data constants for the pm block
`ifndef PM_STATUS_REGS_SVH
`define PM_STATUS_REGS_SVH

`define PM_CSR_OFFSET 12'h000
`define PM_DATA_OFFSET 12'h004
`define PM_AUX_OFFSET 12'h008
`define PM_WAKE_STATUS_BIT 15
`define PM_SCALE_HI 14
`define PM_SCALE_LO 13
`define PM_INDEX_HI 12
`define PM_INDEX_LO 9
`define PM_WAKE_ENABLE_BIT 8
`define PM_DYNAMIC_BIT 4
`define PM_STATE_HI 1
`define PM_STATE_LO 0
`define PM_AUX_DRV_WAKE_BIT 0
`define PM_AUX_GEN_WAKE_BIT 1
`define PM_AUX_CARDBUS_BIT 2
`define PM_STATE_RESET 2'h0
`define PM_INDEX_RESET 4'h0
`define PM_SCALE_LOW_SET 2'h2
`define PM_SCALE_HIGH_SET 2'h0
`define PM_INDEX_LAST_SCALED 4'h8
`define PM_DATA_D0 8'h3C
`define PM_DATA_DX 8'h2A
`define PM_DATA_NONE 8'h00
`define PM_HTRANS_NONSEQ 2'h2

`endif

// ===== rtl/pm_status_pkg.sv
// types for the power management control and status block
package pm_status_pkg;
	typedef enum logic [1:0]
	{
		PWR_D0 = 2'h0,
		PWR_D1 = 2'h1,
		PWR_D2 = 2'h2,
		PWR_D3 = 2'h3
	} power_state_t;

	typedef struct packed
	{
		logic sel;
		logic [1:0] trans;
		logic write;
		logic [2:0] size;
		logic [11:0] addr;
	} ahb_req_t;
endpackage

// ===== tb/pm_host_model.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/1ps
module pm_host_model
(
	// clock
	input wire logic clk,
	// ahb-lite master side
	output logic hsel,
	output logic [11:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end

	// called just after a rising edge; returns just after one
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
	begin
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		q = hrdata;
		// released data line must not keep showing the old word
		hwdata <= ~d;
	end
	endtask
endmodule // pm_host_model

// ===== tb/testbench.sv
// self-checking bench for the power management status block
`timescale 1ns/1ps
module testbench;
	logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, wake_event;
	logic pme_n_out, pme_n_oe, driver_wake_status, general_wake_flag;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	pm_status_pkg::power_state_t power_state;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	assign hready = hreadyout;

	power_mgmt_control_status dut (.clk(clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .wake_event(wake_event),
		.pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe),
		.power_state(power_state), .driver_wake_status(driver_wake_status),
		.general_wake_flag(general_wake_flag));

	pm_host_model host (.clk(clk), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h00000000, q);
	endtask

	task automatic end_of_test;
	begin
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic reset_values;
	begin
		rd(12'h000);
		check(q, 32'h00004000);
		check({31'h0, pme_n_oe}, 32'h00000000);
		rd(12'h004);
		check(q, 32'h0000003C);
		rd(12'h0FC);
		check(q, 32'h00000000);
		check({31'h0, hresp}, 32'h00000000);
	end
	endtask

	// every index, with ones thrown at read-only and reserved bits
	task automatic index_sweep;
		logic [31:0] base;
		logic [7:0] dexp;
	begin
		for (int i = 0; i < 16; i++)
		begin
			base = 32'(i) << 9;
			wr(12'h000, base | 32'h000060FC);
			rd(12'h000);
			check(q, base | ((i <= 8) ? 32'h00004000 : 32'h0));
			check(q & 32'h000000EC, 32'h00000000);
			check(q & 32'h00000010, 32'h00000000);
			rd(12'h004);
			dexp = (i == 0 || i == 4) ? 8'h3C : (i <= 7) ? 8'h2A : 8'h00;
			check(q, {24'h0, dexp});
		end
	end
	endtask

	task automatic state_sweep;
	begin
		for (int s = 3; s >= 0; s--)
		begin
			wr(12'h000, 32'(s));
			rd(12'h000);
			check(q, 32'h00004000 | 32'(s));
			check({30'h0, power_state}, 32'(s));
		end
	end
	endtask

	task automatic wake_flow;
	begin
		wr(12'h008, 32'h00000004);
		wake_event <= 1'b1;
		repeat (6) @(posedge clk);
		wake_event <= 1'b0;
		rd(12'h000);
		check(q, 32'h0000C000);
		check({31'h0, pme_n_oe}, 32'h00000000);
		check({31'h0, driver_wake_status}, 32'h00000001);
		wr(12'h000, 32'h00000100);
		repeat (2) @(posedge clk);
		check({31'h0, pme_n_oe}, 32'h00000001);
		rd(12'h000);
		check(q, 32'h0000C100);
		wr(12'h000, 32'h00008100);
		#1;
		check({31'h0, pme_n_oe}, 32'h00000000);
		check({31'h0, driver_wake_status}, 32'h00000000);
		check({31'h0, general_wake_flag}, 32'h00000000);
		rd(12'h000);
		check(q, 32'h00004100);
		check({31'h0, pme_n_out}, 32'h00000000);
	end
	endtask

	// general flag kept outside cardbus, then a reset in mid-run
	task automatic wake_then_reset;
	begin
		wr(12'h008, 32'h00000000);
		wake_event <= 1'b1;
		repeat (6) @(posedge clk);
		wake_event <= 1'b0;
		wr(12'h000, 32'h00008103);
		#1;
		check({31'h0, pme_n_oe}, 32'h00000000);
		rd(12'h008);
		check(q, 32'h00000002);
		check({30'h0, power_state}, 32'h00000003);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check({30'h0, power_state}, 32'h00000000);
		check({31'h0, general_wake_flag}, 32'h00000000);
		check({31'h0, pme_n_oe}, 32'h00000000);
		rd(12'h000);
		check(q, 32'h00004000);
	end
	endtask

	// ----------------------------------------
	// clock, timeout, main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			end_of_test();
		end
	end

	initial
	begin
		rst = 1'b1;
		wake_event = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		reset_values();
		index_sweep();
		state_sweep();
		wake_flow();
		wake_then_reset();
		end_of_test();
	end
endmodule // testbench
